// ---- rtl/regwr_decoder.sv ----
// Register write command decoder with response frame builder
`timescale 1ns/10ps
// Notes on behaviour
// - Frame address equal to a nonzero node address performs write and sends response.
// - Other addresses, broadcast included, dropped silently except node-address broadcast case.
// - Command field 1000 is decoded as register write.
// - Data bits 15..8 carry the target byte address.
// - Data bits 7..0 carry the byte value to store.
// - Response carries own node address, command 1000 and 8-bit CRC.
// - Response data is word pair after write: odd byte high, even low.
// - Write outside map changes nothing; response data all zeros.
// - Write to read-only register changes nothing; response shows current pair.
// - Broadcast write accepted only to node address register while it is zero.
module regwr_decoder #(
   parameter logic [7:0] MAP_LAST = regwr_pkg::MAP_LAST,
   parameter logic [7:0] RO_FIRST = regwr_pkg::RO_FIRST
) (
   // Clock, reset, enable
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_ce,
   // Received frame
   input  wire logic        i_frame_valid,
   input  wire logic [31:0] i_frame,
   // Register file port
   output logic             o_wr_en,
   output logic      [7:0]  o_wr_addr,
   output logic      [7:0]  o_wr_data,
   output logic      [7:0]  o_rd_addr,
   input  wire logic [15:0] i_rd_data,
   // Node address
   output logic      [3:0]  o_node_address,
   // Response frame
   output logic             o_resp_valid,
   output logic      [31:0] o_resp
);
   // =========================================
   // Reset release
   logic rst_s1_r;
   logic rst_s2_r;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   wire logic rstn_int = rst_s2_r;

   // =========================================
   // Frame fields
   wire logic [3:0] f_addr = i_frame[regwr_pkg::ADDR_MSB:regwr_pkg::ADDR_LSB];
   wire logic [3:0] f_cmd  = i_frame[regwr_pkg::CMD_MSB:regwr_pkg::CMD_LSB];
   wire logic [7:0] f_tba  = i_frame[regwr_pkg::TBA_MSB:regwr_pkg::TBA_LSB];
   wire logic [7:0] f_dat  = i_frame[regwr_pkg::WDAT_MSB:regwr_pkg::WDAT_LSB];
   wire logic [7:0] f_crc  = i_frame[regwr_pkg::CRC_MSB:regwr_pkg::CRC_LSB];

   logic [7:0] rx_crc;
   logic [7:0] tx_crc;
   crc8_calc u_rx_crc (
      .i_msg (i_frame[31:8]),
      .o_crc (rx_crc)
   );

   // =========================================
   // State
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_SEND = 3'b100
   } state_e;

   state_e      state_r, state_nxt;
   logic        wr_en_r, wr_en_nxt;
   logic [7:0]  wr_addr_r, wr_addr_nxt;
   logic [7:0]  wr_data_r, wr_data_nxt;
   logic        out_map_r, out_map_nxt;
   logic [3:0]  node_r, node_nxt;
   logic        resp_v_r, resp_v_nxt;
   logic [31:0] resp_r, resp_nxt;

   // =========================================
   // Response data
   // Node address byte is held here, not in the external file
   logic [15:0] resp_dat;
   always_comb begin
      if (out_map_r) begin
         resp_dat = regwr_pkg::RESP_ZERO;
      end else if (wr_addr_r[7:1] == regwr_pkg::NODE_ADDR_BYTE[7:1]) begin
         resp_dat = {4'h0, node_r, i_rd_data[7:0]};
      end else begin
         resp_dat = i_rd_data;
      end
   end

   crc8_calc u_tx_crc (
      .i_msg ({node_r, regwr_pkg::CMD_WRITE, resp_dat}),
      .o_crc (tx_crc)
   );

   // =========================================
   // Decode
   logic crc_ok, is_wr, own_hit, glob_hit, in_map, writable, accept;
   always_comb begin
      crc_ok   = (rx_crc == f_crc);
      is_wr    = (f_cmd == regwr_pkg::CMD_WRITE);
      // Broadcast never counts as own address, even before one is assigned
      own_hit  = (f_addr == node_r) && (f_addr != regwr_pkg::GLOBAL_ADDR);
      glob_hit = (f_addr == regwr_pkg::GLOBAL_ADDR) && (node_r == regwr_pkg::GLOBAL_ADDR)
                 && (f_tba == regwr_pkg::NODE_ADDR_BYTE);
      in_map   = (f_tba <= MAP_LAST);
      writable = in_map && !(f_tba >= RO_FIRST && f_tba != regwr_pkg::NODE_ADDR_BYTE);
      accept   = i_frame_valid && crc_ok && is_wr && (own_hit || glob_hit);
   end

   always_comb begin
      state_nxt   = state_r;
      wr_en_nxt   = 1'b0;
      wr_addr_nxt = wr_addr_r;
      wr_data_nxt = wr_data_r;
      out_map_nxt = out_map_r;
      node_nxt    = node_r;
      resp_v_nxt  = 1'b0;
      resp_nxt    = resp_r;
      case (state_r)
         ST_IDLE: begin
            if (accept) begin
               wr_addr_nxt = f_tba;
               wr_data_nxt = f_dat;
               out_map_nxt = !in_map;
               wr_en_nxt   = writable && (f_tba != regwr_pkg::NODE_ADDR_BYTE);
               if (f_tba == regwr_pkg::NODE_ADDR_BYTE) begin
                  node_nxt = f_dat[3:0];
               end
               state_nxt = ST_READ;
            end
         end
         ST_READ: begin
            // Readback one cycle after the write lands
            state_nxt = ST_SEND;
         end
         ST_SEND: begin
            resp_nxt = {node_r, regwr_pkg::CMD_WRITE, resp_dat, tx_crc};
            resp_v_nxt = 1'b1;
            state_nxt  = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge rstn_int) begin
      if (!rstn_int) begin
         state_r   <= ST_IDLE;
         wr_en_r   <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
         out_map_r <= 1'b0;
         node_r    <= regwr_pkg::NODE_ADDR_RST;
         resp_v_r  <= 1'b0;
         resp_r    <= 32'h00000000;
      end else if (i_ce) begin
         state_r   <= state_nxt;
         wr_en_r   <= wr_en_nxt;
         wr_addr_r <= wr_addr_nxt;
         wr_data_r <= wr_data_nxt;
         out_map_r <= out_map_nxt;
         node_r    <= node_nxt;
         resp_v_r  <= resp_v_nxt;
         resp_r    <= resp_nxt;
      end
   end

   // =========================================
   // Outputs
   logic [7:0] rd_addr_r;
   always_ff @(posedge i_clk or negedge rstn_int) begin
      if (!rstn_int) begin
         rd_addr_r <= 8'h00;
      end else if (i_ce) begin
         rd_addr_r <= {wr_addr_nxt[7:1], 1'b0};
      end
   end

   assign o_wr_en        = wr_en_r;
   assign o_wr_addr      = wr_addr_r;
   assign o_wr_data      = wr_data_r;
   assign o_rd_addr      = rd_addr_r;
   assign o_node_address = node_r;
   assign o_resp_valid   = resp_v_r;
   assign o_resp         = resp_r;
endmodule : regwr_decoder

// ---- rtl/regwr_pkg.sv ----
// Constants for the bus register write command decoder
package regwr_pkg;
   // =========================================
   // Frame layout
   localparam int FRAME_W      = 32;
   localparam int ADDR_MSB     = 31;
   localparam int ADDR_LSB     = 28;
   localparam int CMD_MSB      = 27;
   localparam int CMD_LSB      = 24;
   localparam int TBA_MSB      = 23;
   localparam int TBA_LSB      = 16;
   localparam int WDAT_MSB     = 15;
   localparam int WDAT_LSB     = 8;
   localparam int CRC_MSB      = 7;
   localparam int CRC_LSB      = 0;
   // =========================================
   // Codes and values
   localparam logic [3:0] CMD_WRITE      = 4'h8;
   localparam logic [3:0] GLOBAL_ADDR    = 4'h0;
   localparam logic [7:0] CRC_POLY       = 8'h2F;
   localparam logic [7:0] CRC_SEED       = 8'hFF;
   localparam logic [3:0] NODE_ADDR_RST  = 4'h0;
   localparam logic [7:0] NODE_ADDR_BYTE = 8'h11;
   localparam logic [15:0] RESP_ZERO     = 16'h0000;
   // =========================================
   // Map limits
   localparam logic [7:0] MAP_LAST       = 8'h3F;
   localparam logic [7:0] RO_FIRST       = 8'h30;
endpackage : regwr_pkg

// ---- rtl/crc8_calc.sv ----
// Combinational CRC-8 over a 24-bit message, MSB first
`timescale 1ns/10ps
module crc8_calc #(
   parameter logic [7:0] POLY = regwr_pkg::CRC_POLY,
   parameter logic [7:0] SEED = regwr_pkg::CRC_SEED
) (
   // Message in
   input  wire logic [23:0] i_msg,
   // Checksum out
   output logic      [7:0]  o_crc
);
   always_comb begin
      logic [7:0] c;
      c = SEED;
      for (int k = 23; k >= 0; k--) begin
         if (c[7] ^ i_msg[k]) begin
            c = {c[6:0], 1'b0} ^ POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      o_crc = c;
   end
endmodule : crc8_calc

// ---- tb/regwr_chk.sv ----
// Port checker for the register write decoder
`timescale 1ns/10ps
module regwr_chk (
   // Inputs
   input wire logic        i_clk,
   input wire logic        i_rstn,
   input wire logic        i_frame_valid,
   input wire logic [31:0] i_frame,
   input wire logic [15:0] i_rd_data,
   // Outputs
   input wire logic        o_wr_en,
   input wire logic [7:0]  o_wr_addr,
   input wire logic [7:0]  o_wr_data,
   input wire logic [7:0]  o_rd_addr,
   input wire logic [3:0]  o_node_address,
   input wire logic        o_resp_valid,
   input wire logic [31:0] o_resp
);
   // ==========
   // Checks
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_wr; o_wr_en ##2 o_resp_valid; endsequence
   property p_lat; o_wr_en |-> s_wr; endproperty
   a_lat: assert property (p_lat) else $error("late response");
   property p_src; o_resp_valid |-> $past(i_frame_valid, 3); endproperty
   a_src: assert property (p_src) else $error("response without frame");
   property p_cmd; o_wr_en |-> $past(i_frame[27:24]) == 4'h8; endproperty
   a_cmd: assert property (p_cmd) else $error("write from other command");
   property p_fld; o_wr_en |-> {o_wr_addr, o_wr_data} == $past(i_frame[23:8]); endproperty
   a_fld: assert property (p_fld) else $error("write fields wrong");
   property p_hdr; o_resp_valid |-> o_resp[31:24] == {o_node_address, 4'h8}; endproperty
   a_hdr: assert property (p_hdr) else $error("response header wrong");
   property p_pair; o_resp_valid && o_wr_addr < 8'h40
      |-> o_resp[23:8] == (o_wr_addr[7:1] == 7'h08 ? {4'h0, o_node_address, $past(i_rd_data[7:0])}
                                                    : $past(i_rd_data))
          && o_rd_addr == {o_wr_addr[7:1], 1'b0}; endproperty
   a_pair: assert property (p_pair) else $error("response data wrong");
   property p_out; o_resp_valid && o_wr_addr > 8'h3F |-> o_resp[23:8] == 16'h0000; endproperty
   a_out: assert property (p_out) else $error("outside data not zero");
   property p_ro; o_wr_en |-> o_wr_addr < 8'h30; endproperty
   a_ro: assert property (p_ro) else $error("protected write");
   property p_bcast; o_wr_en |-> o_node_address != 4'h0; endproperty
   a_bcast: assert property (p_bcast) else $error("write from broadcast frame");
endmodule : regwr_chk

// ---- tb/regfile_model.sv ----
// Register file model behind the decoder write port
`timescale 1ns/10ps
module regfile_model (
   // Write port and readback
   input  wire logic        i_clk,
   input  wire logic        i_wr_en,
   input  wire logic [7:0]  i_wr_addr,
   input  wire logic [7:0]  i_wr_data,
   input  wire logic [7:0]  i_rd_addr,
   output logic      [15:0] o_rd_data
);
   logic [7:0] mem [256];
   // ==========
   // Nonzero contents except byte 8'h5A so protected and unmapped reads are visible
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
   always @(posedge i_clk) if (i_wr_en) mem[i_wr_addr] <= i_wr_data;
   assign o_rd_data = {mem[i_rd_addr | 8'h01], mem[i_rd_addr & 8'hFE]};
endmodule : regfile_model

// ---- tb/testbench.sv ----
// Self-checking bench for the register write decoder
`timescale 1ns/10ps
module testbench;
   logic        i_clk = 1'b0;
   logic        i_rstn = 1'b0;
   logic        i_frame_valid = 1'b0;
   logic        i_ce = 1'b1;
   logic [31:0] i_frame = 32'h0;
   logic        o_wr_en, o_resp_valid;
   logic [7:0]  o_wr_addr, o_wr_data, o_rd_addr, m [256];
   logic [15:0] i_rd_data;
   logic [3:0]  o_node_address, node = 4'h0;
   logic [31:0] o_resp;
   int          n_fail = 0, tests_run = 0;
   integer      seed = 21662;
   regwr_decoder i_dut (.i_clk, .i_rstn, .i_ce, .i_frame_valid, .i_frame, .o_wr_en, .o_wr_addr,
      .o_wr_data, .o_rd_addr, .i_rd_data, .o_node_address, .o_resp_valid, .o_resp);
   regfile_model i_rf (.i_clk, .i_wr_en(o_wr_en), .i_wr_addr(o_wr_addr), .i_wr_data(o_wr_data),
      .i_rd_addr(o_rd_addr), .o_rd_data(i_rd_data));
   initial forever #4 i_clk = ~i_clk;
   // ==========
   // Model and helpers
   task automatic chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [7:0] crc(input logic [23:0] d);
      logic [7:0] c;
      c = 8'hFF;
      for (int i = 23; i >= 0; i--) c = (c << 1) ^ ((c[7] ^ d[i]) ? 8'h2F : 8'h00);
      return c;
   endfunction : crc
   function automatic logic [31:0] fr(input logic [3:0] a, input logic [7:0] t, v);
      return {a, 4'h8, t, v, crc({a, 4'h8, t, v})};
   endfunction : fr
   task automatic send(input logic [31:0] f);
      logic acc, wr;
      logic [7:0] t;
      logic [15:0] d;
      t = f[23:16];
      acc = crc(f[31:8]) == f[7:0] && f[27:24] == 4'h8
         && ((f[31:28] == node && node != 4'h0) || (f[31:28] == 4'h0 && node == 4'h0 && t == 8'h11));
      wr = acc && t < 8'h30 && t != 8'h11;
      if (acc && t == 8'h11) node = f[11:8];
      if (wr) m[t] = f[15:8];
      d = t > 8'h3F ? 16'h0000 : t[7:1] == 7'h08 ? {4'h0, node, m[8'h10]} : {m[t | 8'h01], m[t & 8'hFE]};
      i_frame_valid = 1'b1;
      i_frame = f;
      @(posedge i_clk) #1;
      i_frame_valid = 1'b0;
      chk(o_wr_en, wr);
      if (wr) chk({o_wr_addr, o_wr_data}, f[23:8]);
      if (acc) chk(o_rd_addr, t & 8'hFE);
      repeat (2) @(posedge i_clk) #1;
      chk(o_resp_valid, acc);
      if (acc) chk(o_resp, {node, 4'h8, d, crc({node, 4'h8, d})});
      chk(o_node_address, node);
      @(posedge i_clk) #1;
   endtask : send
   task automatic end_sim();
      if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   // ==========
   // Sequence
   initial begin
      logic [31:0] r, f;
      for (int i = 0; i < 256; i++) m[i] = 8'(i) ^ 8'h5A;
      repeat (10) @(posedge i_clk);
      #1 i_rstn = 1'b1;
      repeat (3) @(posedge i_clk) #1;
      send(fr(4'h0, 8'h05, 8'hA5));
      send(fr(4'h0, 8'h11, 8'h05));
      send(fr(4'h0, 8'h11, 8'h07));
      // Frozen enable: a valid frame must leave no trace
      i_ce = 1'b0;
      i_frame_valid = 1'b1;
      i_frame = fr(node, 8'h05, 8'h3C);
      @(posedge i_clk) #1;
      i_frame_valid = 1'b0;
      chk(o_wr_en, 1'b0);
      repeat (2) @(posedge i_clk) #1;
      chk(o_resp_valid, 1'b0);
      i_ce = 1'b1;
      @(posedge i_clk) #1;
      repeat (300) begin
         r = $random(seed);
         f = fr(r[8] ? node : r[12:9], r[7:0] % 8'h50, r[23:16]);
         if (f[23:16] == 8'h11) f = fr(f[31:28], 8'h11, {4'h0, node});
         if (r[26:24] == 3'h0) f = {f[31:28], r[31:28], f[23:8], crc({f[31:28], r[31:28], f[23:8]})};
         if (r[26:24] == 3'h1) f[7:0] = ~f[7:0];
         send(f);
      end
      // Mid-run reset clears the node address, register file keeps its bytes
      i_rstn = 1'b0;
      @(posedge i_clk) #1;
      chk(o_node_address, 4'h0);
      chk({o_wr_en, o_resp_valid}, 2'b00);
      i_rstn = 1'b1;
      node = 4'h0;
      repeat (3) @(posedge i_clk) #1;
      send(fr(4'h0, 8'h20, 8'h66));
      send(fr(4'h0, 8'h11, 8'h0C));
      send(fr(4'hC, 8'h10, 8'h99));
      end_sim();
   end
   initial begin
      #40000;
      n_fail++;
      end_sim();
   end
endmodule : testbench
bind regwr_decoder regwr_chk i_chk (.i_clk, .i_rstn, .i_frame_valid, .i_frame, .i_rd_data, .o_wr_en,
   .o_wr_addr, .o_wr_data, .o_rd_addr, .o_node_address, .o_resp_valid, .o_resp);
